// [pkg/supervisor_pkg.sv]
// constants shared by the supervisor and its kick filter; the synchroniser uses none of them
// assumes a single 100 MHz clock; the ns times below are turned into cycles here
`default_nettype none
package supervisor_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	// internal timebase: one tick per millisecond
	localparam int unsigned TICK_NS = 1000000;
	localparam int unsigned TICK_CYC = TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned KICK_MIN_NS = 100;
	localparam int unsigned KICK_MIN_CYC =
		(KICK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CE_HOLD_NS = 12000;
	localparam int unsigned CE_HOLD_CYC = CE_HOLD_NS / CLK_PERIOD_NS;
	localparam int unsigned CE_HOLD_W = 11;
	// periods in ticks; internal ticks are milliseconds
	localparam int unsigned PER_W = 16;
	localparam logic [15:0] INT_WD_SHORT = 16'h0064; // 100 ms
	localparam logic [15:0] INT_WD_LONG = 16'h0640; // 1.6 s
	localparam logic [15:0] INT_RST = 16'h00C8; // 200 ms
	localparam logic [15:0] EXT_WD_NORMAL = 16'h0400; // 1024 clocks
	localparam logic [15:0] EXT_WD_FIRST = 16'h1000; // 4096 clocks
	localparam logic [15:0] EXT_RST = 16'h0800; // 2048 clocks
	// reset sequencer states
	typedef enum logic [2:0] {
		ST_LOW = 3'h1,
		ST_PULSE = 3'h2,
		ST_RUN = 3'h4
	} rst_state_e;
endpackage
`default_nettype wire

// [verilog/sync_pair.sv]
// two-flop synchroniser for a bundle of asynchronous levels
// assumes the levels are quasi-static compared with the clock
`default_nettype none
module sync_pair #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	if (W < 1) begin : g_chk
		$error("sync_pair needs at least one bit");
	end

	always_comb begin
		next_meta = d;
		next_q = meta;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= next_meta;
			q <= next_q;
		end
	end
endmodule
`default_nettype wire

// [verilog/kick_filter.sv]
// pulse-width filter on the synchronised kick level
// assumes the input is already on the clk domain
`default_nettype none
module kick_filter
	import supervisor_pkg::*;
#(
	parameter int unsigned MIN_CYC = supervisor_pkg::KICK_MIN_CYC
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic level,
	output var  logic stable,
	output var  logic change
);
	localparam int unsigned CW = $clog2(MIN_CYC + 1);
	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic          next_stable;
	logic          next_change;

	if (MIN_CYC < 1) begin : g_chk
		$error("kick_filter needs a width of at least one cycle");
	end

	// a new level counts only once held for MIN_CYC cycles
	always_comb begin
		next_cnt = '0;
		next_stable = stable;
		next_change = 1'b0;
		if (level != stable) begin
			if (cnt == CW'(MIN_CYC - 1)) begin
				next_stable = level;
				next_change = 1'b1;
			end else begin
				next_cnt = cnt + CW'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
			stable <= 1'b0;
			change <= 1'b0;
		end else begin
			cnt <= next_cnt;
			stable <= next_stable;
			change <= next_change;
		end
	end

	filter_width_a: assert property (@(posedge clk) disable iff (!rst_n)
		change |-> $past(level, MIN_CYC) == stable)
		else $error("kick change accepted before its minimum width");
endmodule
`default_nettype wire

// [verilog/supervisor_watchdog_reset_ce_gate.sv]
// supervisor: reset stretcher, watchdog and chip-enable gate
// assumes supply comparator, battery mode, kick level/float and chip-enable
// arrive as asynchronous digital levels; the analogue parts live outside
`default_nettype none
module supervisor_watchdog_reset_ce_gate
	import supervisor_pkg::*;
#(
	parameter int unsigned TICK_CYC = supervisor_pkg::TICK_CYC,
	parameter int unsigned KICK_MIN_CYC = supervisor_pkg::KICK_MIN_CYC,
	parameter int unsigned CE_HOLD_CYC = supervisor_pkg::CE_HOLD_CYC
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic supply_low,
	input  wire logic battery_mode,
	input  wire logic watchdog_kick_input,
	input  wire logic watchdog_kick_float,
	input  wire logic timebase_select,
	input  wire logic timebase_pin,
	input  wire logic ce_in_n,
	output var  logic reset_n_out,
	output var  logic reset_hi_o,
	output var  logic reset_hi_oe,
	output var  logic watchdog_fault_out,
	output var  logic kick_bias_en,
	output var  logic ce_out_n,
	output var  logic ce_in_hiz
);
	import supervisor_pkg::*;

	localparam int unsigned DW = $clog2(TICK_CYC);

	if (TICK_CYC < 2 || CE_HOLD_CYC < 1 || CE_HOLD_CYC >= (1 << CE_HOLD_W))
	begin : g_chk
		$error("supervisor timing parameters out of range");
	end

	// reset release through two flops
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	logic low_s;
	logic batt_s;
	logic kick_s;
	logic float_s;
	logic sel_s;
	logic pin_s;
	logic ce_s;

	sync_pair #(
		.W(7)
	) u_sync (
		.clk  (clk),
		.rst_n(rst_n),
		.d    ({supply_low, battery_mode, watchdog_kick_input,
			watchdog_kick_float, timebase_select, timebase_pin, ce_in_n}),
		.q    ({low_s, batt_s, kick_s, float_s, sel_s, pin_s, ce_s})
	);

	logic kick_stable;
	logic kick_change;

	kick_filter #(
		.MIN_CYC(KICK_MIN_CYC)
	) u_kick (
		.clk   (clk),
		.rst_n (rst_n),
		.level (kick_s),
		.stable(kick_stable),
		.change(kick_change)
	);

	// timebase: internal millisecond divider or rising edges of the pin
	logic          ext_mode;
	logic [DW-1:0] div;
	logic [DW-1:0] next_div;
	logic          pin_prev;
	logic          tick;
	logic [15:0]   wd_normal;
	logic [15:0]   wd_first;
	logic [15:0]   rst_len;

	always_comb begin
		ext_mode = !sel_s;
		next_div = div + DW'(1);
		if (div == DW'(TICK_CYC - 1) || ext_mode) begin
			next_div = '0;
		end
		if (ext_mode) begin
			tick = pin_s && !pin_prev;
			wd_normal = EXT_WD_NORMAL;
			wd_first = EXT_WD_FIRST;
			rst_len = EXT_RST;
		end else begin
			tick = (div == DW'(TICK_CYC - 1));
			wd_normal = pin_s ? INT_WD_LONG : INT_WD_SHORT;
			wd_first = INT_WD_LONG;
			rst_len = INT_RST;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div <= '0;
			pin_prev <= 1'b0;
		end else begin
			div <= next_div;
			pin_prev <= pin_s;
		end
	end

	// reset sequencer and watchdog
	rst_state_e st;
	rst_state_e next_st;
	logic [PER_W-1:0] rcnt;
	logic [PER_W-1:0] next_rcnt;
	logic [PER_W-1:0] wd_cnt;
	logic [PER_W-1:0] next_wd_cnt;
	logic             first;
	logic             next_first;
	logic             next_fault;
	logic             low_cond;
	logic             wd_off;
	logic             activity;
	logic             expire;
	logic [PER_W-1:0] wd_limit;

	always_comb begin
		// battery mode implies supply below threshold; switchover never gates
		low_cond = low_s || batt_s;
		wd_off = low_s || float_s;
		activity = kick_change && !wd_off;
		wd_limit = first ? wd_first : wd_normal;
		// a low supply or battery mode wins over a timeout in the same cycle
		expire = (st == ST_RUN) && !low_cond && !wd_off && !activity
			&& tick && (wd_cnt == wd_limit - PER_W'(1));
		next_st = st;
		next_rcnt = rcnt;
		next_wd_cnt = wd_cnt;
		next_first = first;
		unique case (st)
			ST_LOW: begin
				next_rcnt = '0;
				if (!low_cond) begin
					next_st = ST_PULSE;
				end
			end
			ST_PULSE: begin
				next_wd_cnt = '0;
				if (low_cond) begin
					next_st = ST_LOW;
				end else if (tick) begin
					if (rcnt == rst_len - PER_W'(1)) begin
						next_st = ST_RUN;
						next_first = 1'b1;
					end else begin
						next_rcnt = rcnt + PER_W'(1);
					end
				end
			end
			ST_RUN: begin
				if (low_cond) begin
					next_st = ST_LOW;
				end else if (expire) begin
					next_st = ST_PULSE;
					next_rcnt = '0;
				end else if (wd_off || activity) begin
					next_wd_cnt = '0;
					if (activity) begin
						next_first = 1'b0;
					end
				end else if (tick) begin
					next_wd_cnt = wd_cnt + PER_W'(1);
				end
			end
		endcase
		// fault clears on a transition; a disabled watchdog shows high
		next_fault = watchdog_fault_out;
		if (wd_off || kick_change) begin
			next_fault = 1'b1;
		end else if (expire) begin
			next_fault = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= ST_LOW;
			rcnt <= '0;
			wd_cnt <= '0;
			first <= 1'b1;
			watchdog_fault_out <= 1'b1;
		end else begin
			st <= next_st;
			rcnt <= next_rcnt;
			wd_cnt <= next_wd_cnt;
			first <= next_first;
			watchdog_fault_out <= next_fault;
		end
	end

	// chip-enable gate
	logic                 path_on;
	logic                 next_path_on;
	logic                 grace;
	logic                 next_grace;
	logic [CE_HOLD_W-1:0] gcnt;
	logic [CE_HOLD_W-1:0] next_gcnt;
	logic                 rst_next;

	always_comb begin
		rst_next = (next_st != ST_RUN);
		next_path_on = 1'b0;
		next_grace = 1'b0;
		next_gcnt = '0;
		if (!rst_next) begin
			next_path_on = 1'b1;
		end else if (path_on && !grace && !ce_s) begin
			// a cycle already under way may finish its write
			next_path_on = 1'b1;
			next_grace = 1'b1;
		end else if (grace && !ce_s
			&& gcnt != CE_HOLD_W'(CE_HOLD_CYC - 1)) begin
			next_path_on = 1'b1;
			next_grace = 1'b1;
			next_gcnt = gcnt + CE_HOLD_W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			path_on <= 1'b0;
			grace <= 1'b0;
			gcnt <= '0;
			reset_n_out <= 1'b0;
			reset_hi_o <= 1'b0;
			reset_hi_oe <= 1'b0;
			kick_bias_en <= 1'b0;
			ce_out_n <= 1'b1;
			ce_in_hiz <= 1'b1;
		end else begin
			path_on <= next_path_on;
			grace <= next_grace;
			gcnt <= next_gcnt;
			reset_n_out <= !rst_next;
			reset_hi_o <= 1'b0;
			reset_hi_oe <= !rst_next;
			kick_bias_en <= !low_s;
			ce_out_n <= next_path_on ? ce_s : 1'b1;
			ce_in_hiz <= !next_path_on;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	low_holds_reset_a: assert property (
		low_s |-> ##2 !reset_n_out)
		else $error("reset not asserted while supply low");
	batt_holds_reset_a: assert property (
		batt_s |-> ##2 (!reset_n_out && !reset_hi_oe))
		else $error("reset not asserted in battery mode");
	reset_inverse_a: assert property (
		reset_hi_oe == reset_n_out && !reset_hi_o)
		else $error("active-high reset is not the inverse");
	fault_with_reset_a: assert property (
		$fell(watchdog_fault_out) |-> !reset_n_out && st == ST_PULSE)
		else $error("watchdog fault without a reset pulse");
	kick_restart_a: assert property (
		(activity && st == ST_RUN && !low_cond) |=> wd_cnt == '0)
		else $error("kick did not restart the watchdog");
	disabled_fault_high_a: assert property (
		wd_off |=> watchdog_fault_out && !expire)
		else $error("fault output low while watchdog disabled");
	bias_off_low_a: assert property (
		low_s |=> !kick_bias_en)
		else $error("kick bias left on with supply low");
	fault_until_kick_a: assert property (
		(!watchdog_fault_out && !wd_off && !kick_change)
		|=> !watchdog_fault_out)
		else $error("fault output released without a kick");
	pulse_then_first_a: assert property (
		(st == ST_PULSE && next_st == ST_RUN) |=> first && wd_cnt == '0)
		else $error("post-reset period not armed after pulse");
	ce_blocked_a: assert property (
		(st != ST_RUN && next_st != ST_RUN && !grace)
		|=> ce_out_n && ce_in_hiz)
		else $error("chip-enable passed during reset");
	ce_grace_end_a: assert property (
		(grace && ce_s) |=> !grace && ce_out_n)
		else $error("chip-enable grace outlived host release");
	ce_grace_bound_a: assert property (
		gcnt <= CE_HOLD_W'(CE_HOLD_CYC - 1))
		else $error("chip-enable grace longer than its limit");
endmodule
`default_nettype wire

// [verif/host_model.sv]
// processor side: toggles the kick line and drives the host chip-enable
// assumes the bench starts and stops the kicking and requests chip-enable
`default_nettype none
module host_model (
	input  wire logic        clk,
	input  wire logic        kick_run,
	input  wire logic [31:0] kick_half,
	input  wire logic        ce_req,
	output var  logic        watchdog_kick_input,
	output var  logic        ce_in_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] cnt;

	// a toggle inside the selected period keeps the timer from expiring
	initial begin
		cnt = 32'h0;
		watchdog_kick_input = 1'b0;
		forever begin
			@(posedge clk);
			if (kick_run) begin
				if (cnt >= kick_half - 32'h1) begin
					cnt <= 32'h0;
					watchdog_kick_input <= ~watchdog_kick_input;
				end else begin
					cnt <= cnt + 32'h1;
				end
			end
		end
	end
	assign ce_in_n = ~ce_req;
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// bench for the supervisor: reset stretch, watchdog and chip-enable gate
// assumes shortened tick (10 clocks), filter (2) and chip-enable grace (20)
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic supply_low = 1'b0;
	logic battery_mode = 1'b0;
	logic watchdog_kick_float = 1'b0;
	logic timebase_select = 1'b1;
	logic timebase_pin = 1'b0;
	logic pin_level = 1'b0;
	logic ext_run = 1'b0;
	logic [31:0] kick_half = 32'h12C;
	logic kick_run = 1'b0;
	logic ce_req = 1'b0;
	logic watchdog_kick_input, ce_in_n;
	logic reset_n_out, reset_hi_o, reset_hi_oe, watchdog_fault_out;
	logic kick_bias_en, ce_out_n, ce_in_hiz;
	int   n_errors = 0;
	int   cmp_count = 0;
	int   cycles = 0;

	always #5 clk = ~clk;

	// timebase pin: a plain level, or a clock with a rising edge every two
	always @(posedge clk) begin
		timebase_pin <= ext_run ? ~timebase_pin : pin_level;
	end

	host_model host (.clk(clk), .kick_run(kick_run), .kick_half(kick_half),
		.ce_req(ce_req), .watchdog_kick_input(watchdog_kick_input),
		.ce_in_n(ce_in_n));

	supervisor_watchdog_reset_ce_gate #(.TICK_CYC(10), .KICK_MIN_CYC(2),
		.CE_HOLD_CYC(20)) DUT (.clk(clk), .resetn(resetn),
		.supply_low(supply_low), .battery_mode(battery_mode),
		.watchdog_kick_input(watchdog_kick_input),
		.watchdog_kick_float(watchdog_kick_float),
		.timebase_select(timebase_select), .timebase_pin(timebase_pin),
		.ce_in_n(ce_in_n), .reset_n_out(reset_n_out),
		.reset_hi_o(reset_hi_o), .reset_hi_oe(reset_hi_oe),
		.watchdog_fault_out(watchdog_fault_out),
		.kick_bias_en(kick_bias_en), .ce_out_n(ce_out_n),
		.ce_in_hiz(ce_in_hiz));

	task automatic close_out;
		$display("checks %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// cycles until reset_n_out reaches v, giving up after max
	task automatic wait_rst(input logic v, input int max, output int n);
		n = 0;
		while (reset_n_out !== v && n < max) begin
			wait_cyc(1);
			n++;
		end
	endtask

	// reset period is 200 ticks of 10 clocks, plus sync and tick phase
	task automatic power_up;
		int n;
		check({reset_n_out, reset_hi_oe, ce_out_n, ce_in_hiz}, 4'h3);
		check(watchdog_fault_out, 1'b1);
		wait_rst(1'b1, 3000, n);
		check(n >= 1990 && n <= 2040, 1'b1);
		check({reset_hi_oe, reset_hi_o}, 2'h2);
	endtask

	task automatic ce_pass;
		@(posedge clk) ce_req <= 1'b1;
		wait_cyc(5);
		check({ce_out_n, ce_in_hiz}, 2'h0);
		@(posedge clk) ce_req <= 1'b0;
		wait_cyc(5);
		check(ce_out_n, 1'b1);
		@(posedge clk) ce_req <= 1'b1;
		wait_cyc(5);
	endtask

	// supply drops while the host holds chip-enable low
	task automatic supply_drop;
		int n;
		int m;
		@(posedge clk) supply_low <= 1'b1;
		wait_rst(1'b0, 10, n);
		check(n <= 4, 1'b1);
		check(ce_out_n, 1'b0);
		m = 0;
		while (ce_out_n !== 1'b1 && m < 40) begin
			wait_cyc(1);
			m++;
		end
		check(m >= 15 && m <= 25, 1'b1);
		check({ce_in_hiz, kick_bias_en, reset_hi_oe}, 3'h4);
		check(watchdog_fault_out, 1'b1);
		@(posedge clk) supply_low <= 1'b0;
		wait_cyc(1000);
		check({reset_n_out, ce_out_n, ce_in_hiz}, 3'h3);
		wait_rst(1'b1, 2000, n);
		check(n >= 990 && n <= 1040, 1'b1);
		@(posedge clk) ce_req <= 1'b0;
	endtask

	task automatic battery;
		int n;
		@(posedge clk) battery_mode <= 1'b1;
		wait_rst(1'b0, 10, n);
		check({n <= 4, reset_hi_oe}, 2'h2);
		@(posedge clk) battery_mode <= 1'b0;
		wait_rst(1'b1, 3000, n);
		check(n >= 1990 && n <= 2040, 1'b1);
	endtask

	// static kick: first period 1600 ticks, then activity, then 100 ticks
	task automatic watchdog;
		int n;
		int lows;
		wait_rst(1'b0, 17000, n);
		check(n >= 15980 && n <= 16040, 1'b1);
		check(watchdog_fault_out, 1'b0);
		wait_rst(1'b1, 3000, n);
		check(n >= 1990 && n <= 2040, 1'b1);
		wait_cyc(100);
		check(watchdog_fault_out, 1'b0);
		@(posedge clk) kick_run <= 1'b1;
		// first toggle comes 300 clocks on, then sync and filter delay
		wait_cyc(320);
		check(watchdog_fault_out, 1'b1);
		lows = 0;
		repeat (3000) begin
			wait_cyc(1);
			lows += (reset_n_out !== 1'b1 || watchdog_fault_out !== 1'b1);
		end
		check(lows, 0);
		@(watchdog_kick_input);
		@(posedge clk) kick_run <= 1'b0;
		wait_rst(1'b0, 1500, n);
		check(n >= 980 && n <= 1040, 1'b1);
		wait_rst(1'b1, 3000, n);
		check(n >= 1990 && n <= 2040, 1'b1);
	endtask

	// floating kick line: no timeout however long it stays static
	task automatic float_kick;
		int lows;
		@(posedge clk) watchdog_kick_float <= 1'b1;
		// the fault left by the last timeout clears once float is synced
		wait_cyc(3);
		check(watchdog_fault_out, 1'b1);
		lows = 0;
		repeat (18000) begin
			wait_cyc(1);
			lows += (reset_n_out !== 1'b1 || watchdog_fault_out !== 1'b1);
		end
		check(lows, 0);
	endtask

	// pin high: normal period stays long, so kicks every 1200 clocks,
	// beyond the short period, cause no reset
	task automatic long_normal;
		int lows;
		@(posedge clk) begin
			watchdog_kick_float <= 1'b0;
			pin_level <= 1'b1;
			kick_half <= 32'h4B0;
			kick_run <= 1'b1;
		end
		lows = 0;
		repeat (6000) begin
			wait_cyc(1);
			lows += (reset_n_out !== 1'b1 || watchdog_fault_out !== 1'b1);
		end
		check(lows, 0);
	endtask

	// external timebase, one tick per two clocks; kick goes static
	task automatic ext_clock;
		int n;
		@(watchdog_kick_input);
		@(posedge clk) begin
			kick_run <= 1'b0;
			timebase_select <= 1'b0;
			ext_run <= 1'b1;
		end
		wait_rst(1'b0, 2200, n);
		check(n >= 2040 && n <= 2064, 1'b1);
		check(watchdog_fault_out, 1'b0);
		wait_rst(1'b1, 4200, n);
		check(n >= 4090 && n <= 4100, 1'b1);
		wait_rst(1'b0, 8300, n);
		check(n >= 8186 && n <= 8200, 1'b1);
		ext_run <= 1'b0;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 100000) begin
			n_errors++;
			close_out();
		end
	end

	initial begin
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		#1;
		power_up();
		ce_pass();
		supply_drop();
		battery();
		watchdog();
		float_kick();
		long_normal();
		ext_clock();
		close_out();
	end
endmodule
`default_nettype wire
